// File: hdl/posted_entry_decode.sv
// Decoder for posted-format remap table entries with source checking.
// Assumes request inputs synchronous to clock; the entry arrives whole.
//
// Operation
// - Check type 01: requester id compare on the bits the qualifier selects
// - Check type 10: bus within start/end range
// - Source id used only when present, 01/10
// - Entry 63:38 gives descriptor address 31:6
// - Low descriptor address used only when present
// - Entry 23:16 is vector, only when present
// - Bit 15 set posts, clear remaps
// - No posting capability: mode, urgent reserved zero
// - Bit 14 marks posted request urgent
// - Urgent evaluated only with present and mode
// - Present clear blocks every request
// - Entry 127:96 is address 63:32, bits at or above host width reserved zero
// - Qualifier selects compared requester id bits
// - Bit 1 suppresses fault reporting always
//
// Chosen here: the address map and the address-and-strobe port.
module posted_entry_decode #(
	parameter int ADDR_WIDTH = 8
) (
	input wire logic clock, // System clock, 50 MHz.
	input wire logic sys_rst, // Asynchronous reset, active high.
	input wire logic clockEnable, // Freezes all state while low.
	input wire logic reqValid, // Request present this cycle.
	input wire logic [127:0] reqEntry, // Table entry the request references.
	input wire logic [15:0] reqRequesterId, // Requester id of the request.
	output logic resValid, // High the cycle after each taken request, held while reqValid stays high: result below is new.
	output logic resBlocked, // Request was blocked.
	output logic resPosted, // Request is to be posted.
	output logic resRemapped, // Request goes the remapped way.
	output logic resUrgent, // Posted request is latency sensitive.
	output logic resFaultReport, // Fault is to be recorded and reported.
	output logic [7:0] resVector, // Posted vector.
	output logic [63:0] resDescAddr, // Posted descriptor address.
	input wire logic [ADDR_WIDTH-1:0] regAddr, // Register byte address.
	input wire logic [31:0] regWriteData, // Register write data.
	input wire logic regWrite, // Write strobe.
	input wire logic regRead, // Read strobe.
	output logic [31:0] regReadData, // Read data, cycle after the strobe.
	output logic irq // Level interrupt.
);

	// ********************************************************************
	// Parameter check
	// ********************************************************************
	if (ADDR_WIDTH < 5 || ADDR_WIDTH > 8) begin
		$error("ADDR_WIDTH must lie between 5 and 8");
	end

	// ********************************************************************
	// Registers
	// ********************************************************************
	logic postingCapability_reg;
	logic [6:0] hostAddrWidth_reg;
	logic [3:0] status_reg;
	logic [3:0] status_next;
	logic [3:0] intEnable_reg;
	logic [3:0] eventSet;
	logic [3:0] eventClear;
	logic [31:0] blockCount_reg;
	logic [31:0] readData_next;
	logic [7:0] fullAddr;
	logic take;

	assign take = clockEnable && reqValid;
	assign fullAddr = 8'(regAddr);

	// ********************************************************************
	// Entry decode
	// ********************************************************************
	logic present;
	logic [1:0] checkType;
	logic [1:0] checkQualifier;
	logic [15:0] sourceIdent;
	logic [15:0] qualMask;
	logic requesterMatch;
	logic busInRange;
	logic sourceOk;
	logic reservedBad;
	logic postMode;
	logic decBlocked;
	logic decPosted;
	logic decUrgent;
	logic decFault;
	logic [63:0] rawDescAddr;
	logic [63:0] hostWidthMask;
	logic [63:0] decDescAddr;
	logic [7:0] decVector;

	assign present = reqEntry[posted_entry_pkg::PRESENT_BIT];
	assign checkType = reqEntry[posted_entry_pkg::CHECK_TYPE_HI:posted_entry_pkg::CHECK_TYPE_LO];
	assign checkQualifier = reqEntry[posted_entry_pkg::QUALIFIER_HI:posted_entry_pkg::QUALIFIER_LO];
	assign sourceIdent = reqEntry[posted_entry_pkg::SOURCE_ID_HI:posted_entry_pkg::SOURCE_ID_LO];
	assign rawDescAddr = {reqEntry[posted_entry_pkg::DESC_HIGH_HI:posted_entry_pkg::DESC_HIGH_LO],
		reqEntry[posted_entry_pkg::DESC_LOW_HI:posted_entry_pkg::DESC_LOW_LO],
		{posted_entry_pkg::DESC_ALIGN_BITS{1'b0}}};

	// Address bits at or above the host address width are reserved zero.
	for (genvar i = 0; i < 64; i++) begin : gen_host_width_mask
		assign hostWidthMask[i] = (7'(i) < hostAddrWidth_reg);
	end

	always_comb begin
		case (checkQualifier)
			2'h0: qualMask = posted_entry_pkg::QUAL_MASK_0;
			2'h1: qualMask = posted_entry_pkg::QUAL_MASK_1;
			2'h2: qualMask = posted_entry_pkg::QUAL_MASK_2;
			default: qualMask = posted_entry_pkg::QUAL_MASK_3;
		endcase
	end

	assign requesterMatch = ((sourceIdent ^ reqRequesterId) & qualMask) == 16'h0000;
	assign busInRange = (reqRequesterId[15:8] >= sourceIdent[15:8]) &&
		(reqRequesterId[15:8] <= sourceIdent[7:0]);

	always_comb begin
		case (checkType)
			posted_entry_pkg::CHECK_NONE: sourceOk = 1'b1;
			posted_entry_pkg::CHECK_REQUESTER: sourceOk = requesterMatch;
			posted_entry_pkg::CHECK_BUS_RANGE: sourceOk = busInRange;
			default: sourceOk = 1'b0;
		endcase
	end

	// Without posting support the mode and urgent bits join the reserved set.
	assign reservedBad = (|reqEntry[posted_entry_pkg::RSVD_B_HI:posted_entry_pkg::RSVD_B_LO]) ||
		(|reqEntry[posted_entry_pkg::RSVD_A_HI:posted_entry_pkg::RSVD_A_LO]) ||
		(|reqEntry[posted_entry_pkg::RSVD_MID_HI:posted_entry_pkg::RSVD_MID_LO]) ||
		(|reqEntry[posted_entry_pkg::RSVD_LOW_HI:posted_entry_pkg::RSVD_LOW_LO]) ||
		(|(rawDescAddr & ~hostWidthMask)) ||
		(!postingCapability_reg && (reqEntry[posted_entry_pkg::POST_MODE_BIT] ||
		reqEntry[posted_entry_pkg::URGENT_BIT]));

	// Fields past the present bit, save the fault inhibit bit 1, are looked at only when it is set.
	assign decBlocked = !present || !sourceOk || reservedBad;
	assign postMode = reqEntry[posted_entry_pkg::POST_MODE_BIT] && postingCapability_reg;
	assign decPosted = !decBlocked && postMode;
	assign decUrgent = present && postMode && reqEntry[posted_entry_pkg::URGENT_BIT];
	assign decFault = decBlocked && !reqEntry[posted_entry_pkg::FAULT_INHIBIT_BIT];
	assign decDescAddr = present ? rawDescAddr : 64'h0;
	assign decVector = present ? reqEntry[posted_entry_pkg::VECTOR_HI:posted_entry_pkg::VECTOR_LO] : 8'h00;

	// ********************************************************************
	// Result registers
	// ********************************************************************
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			resValid <= 1'b0;
		end else if (clockEnable) begin
			resValid <= reqValid;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			resBlocked <= 1'b0;
			resPosted <= 1'b0;
			resRemapped <= 1'b0;
			resUrgent <= 1'b0;
			resFaultReport <= 1'b0;
			resVector <= 8'h00;
			resDescAddr <= 64'h0;
		end else if (take) begin
			resBlocked <= decBlocked;
			resPosted <= decPosted;
			resRemapped <= !decBlocked && !postMode;
			resUrgent <= decUrgent && !decBlocked;
			resFaultReport <= decFault;
			resVector <= decVector;
			resDescAddr <= decDescAddr;
		end
	end

	// ********************************************************************
	// Events and interrupt
	// ********************************************************************
	always_comb begin
		eventSet = posted_entry_pkg::EVENT_RESET;
		if (take) begin
			eventSet[posted_entry_pkg::EV_POSTED] = decPosted;
			eventSet[posted_entry_pkg::EV_REMAPPED] = !decBlocked && !postMode;
			eventSet[posted_entry_pkg::EV_BLOCKED] = decBlocked;
			eventSet[posted_entry_pkg::EV_FAULT] = decFault;
		end
		eventClear = posted_entry_pkg::EVENT_RESET;
		if (regWrite && fullAddr == posted_entry_pkg::INT_CLEAR_OFFSET) begin
			eventClear = regWriteData[3:0];
		end
		// A new event in the clearing cycle survives the clear.
		status_next = (status_reg & ~eventClear) | eventSet;
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			status_reg <= posted_entry_pkg::EVENT_RESET;
			irq <= 1'b0;
		end else if (clockEnable) begin
			status_reg <= status_next;
			irq <= |(status_next & intEnable_reg);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			blockCount_reg <= 32'h0;
		end else if (take && decBlocked) begin
			blockCount_reg <= blockCount_reg + 32'h1;
		end
	end

	// ********************************************************************
	// Register port
	// ********************************************************************
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			postingCapability_reg <= posted_entry_pkg::CAP_RESET;
			hostAddrWidth_reg <= posted_entry_pkg::WIDTH_RESET;
			intEnable_reg <= posted_entry_pkg::EVENT_RESET;
		end else if (clockEnable && regWrite) begin
			if (fullAddr == posted_entry_pkg::CTRL_OFFSET) begin
				postingCapability_reg <= regWriteData[posted_entry_pkg::CTRL_CAP_BIT];
				hostAddrWidth_reg <= regWriteData[posted_entry_pkg::CTRL_WIDTH_HI:posted_entry_pkg::CTRL_WIDTH_LO];
			end
			if (fullAddr == posted_entry_pkg::INT_ENABLE_OFFSET) begin
				intEnable_reg <= regWriteData[3:0];
			end
		end
	end

	always_comb begin
		readData_next = 32'h0;
		case (fullAddr)
			posted_entry_pkg::CTRL_OFFSET: begin
				readData_next[posted_entry_pkg::CTRL_CAP_BIT] = postingCapability_reg;
				readData_next[posted_entry_pkg::CTRL_WIDTH_HI:posted_entry_pkg::CTRL_WIDTH_LO] = hostAddrWidth_reg;
			end
			posted_entry_pkg::STATUS_OFFSET: readData_next[3:0] = status_reg;
			posted_entry_pkg::INT_ENABLE_OFFSET: readData_next[3:0] = intEnable_reg;
			posted_entry_pkg::LAST_OFFSET: begin
				readData_next[7:0] = resVector;
				readData_next[8] = resBlocked;
				readData_next[9] = resPosted;
				readData_next[10] = resUrgent;
			end
			posted_entry_pkg::BLOCK_COUNT_OFFSET: readData_next = blockCount_reg;
			default: readData_next = 32'h0;
		endcase
	end

	// Read data stand only in the cycle after the strobe; otherwise zero.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			regReadData <= 32'h0;
		end else if (clockEnable) begin
			regReadData <= regRead ? readData_next : 32'h0;
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************
	sequence takeAbsent;
		take && !present;
	endsequence

	sequence takeClean;
		take && present && !reservedBad;
	endsequence

	sequence takeBlocked;
		take && decBlocked;
	endsequence

	requester_match_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean and (take && checkType == 2'h1 && checkQualifier == 2'h0 && sourceIdent != reqRequesterId)
		|=> resBlocked && !resPosted)
		else $error("Requester id mismatch was not blocked");

	bus_range_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean and (take && checkType == 2'h2 && reqRequesterId[15:8] >= sourceIdent[15:8] &&
		reqRequesterId[15:8] <= sourceIdent[7:0])
		|=> !resBlocked)
		else $error("Bus number inside the range was blocked");

	source_ignored_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean and (take && checkType == 2'h0) |=> !resBlocked && resValid)
		else $error("Source id was examined with no check type");

	desc_address_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean |=> resDescAddr[5:0] == 6'h00 && resDescAddr[31:6] == $past(reqEntry[63:38]))
		else $error("Descriptor address low bits wrong");

	absent_fields_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeAbsent |=> resDescAddr == 64'h0 && resVector == 8'h00 && !resUrgent)
		else $error("Fields of an absent entry were used");

	vector_pass_a: assert property (@(posedge clock) disable iff (sys_rst)
		take && present |=> resVector == $past(reqEntry[23:16]))
		else $error("Posted vector differs from entry");

	mode_select_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean and (take && sourceOk) |=> resPosted == $past(reqEntry[15]) && resRemapped == !$past(reqEntry[15]))
		else $error("Posting mode chose the wrong path");

	no_capability_a: assert property (@(posedge clock) disable iff (sys_rst)
		take && !postingCapability_reg && (reqEntry[15] || reqEntry[14]) |=> resBlocked && !resPosted)
		else $error("Mode or urgent bit accepted without capability");

	urgent_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
		take |=> resUrgent == ($past(decPosted) && $past(reqEntry[14])))
		else $error("Urgent flag does not follow the entry");

	urgent_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		take && !(present && reqEntry[15]) |=> !resUrgent)
		else $error("Urgent flag raised without present and mode");

	absent_block_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeAbsent |=> resBlocked ##0 status_reg[2])
		else $error("Absent entry did not block");

	width_reserved_a: assert property (@(posedge clock) disable iff (sys_rst)
		take && hostAddrWidth_reg < 7'h40 && reqEntry[127] |=> resBlocked)
		else $error("Address bit above host width not refused");

	fault_inhibit_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeBlocked |=> resFaultReport == !$past(reqEntry[1]))
		else $error("Fault report ignores the inhibit bit");

	source_fail_a: assert property (@(posedge clock) disable iff (sys_rst)
		take && !sourceOk |=> resBlocked && !resPosted && !resRemapped)
		else $error("Request failing the source check was delivered");

	clear_race_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeBlocked and (regWrite && fullAddr == posted_entry_pkg::INT_CLEAR_OFFSET &&
		regWriteData[posted_entry_pkg::EV_BLOCKED]) |=> status_reg[posted_entry_pkg::EV_BLOCKED])
		else $error("Clear in the blocking cycle lost the blocked event");

	fault_absent_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeAbsent and (take && !reqEntry[posted_entry_pkg::FAULT_INHIBIT_BIT]) |=> resFaultReport)
		else $error("Absent entry without inhibit reported no fault");

	qualifier_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeClean and (take && checkType == 2'h1 && checkQualifier == 2'h3 &&
		sourceIdent[15:3] == reqRequesterId[15:3]) |=> !resBlocked)
		else $error("Upper requester id match was blocked");

	block_count_a: assert property (@(posedge clock) disable iff (sys_rst)
		takeBlocked |=> blockCount_reg == $past(blockCount_reg) + 32'h1)
		else $error("Blocked request was not counted");

	enable_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
		!clockEnable |=> $stable(status_reg) && $stable(blockCount_reg) && $stable(resValid) && $stable(irq))
		else $error("State moved while the clock enable was low");

endmodule

// File: inc/posted_entry_pkg.sv
// Constants for the posted-format remap table entry decoder.
// Assumes one clock domain and a simple strobe-style register port.
package posted_entry_pkg;

	// ********************************************************************
	// Entry field positions
	// ********************************************************************
	localparam int ENTRY_WIDTH = 128;
	localparam int PRESENT_BIT = 0;
	localparam int FAULT_INHIBIT_BIT = 1;
	localparam int RSVD_LOW_HI = 7;
	localparam int RSVD_LOW_LO = 2;
	localparam int RSVD_MID_HI = 13;
	localparam int RSVD_MID_LO = 12;
	localparam int URGENT_BIT = 14;
	localparam int POST_MODE_BIT = 15;
	localparam int VECTOR_HI = 23;
	localparam int VECTOR_LO = 16;
	localparam int RSVD_A_HI = 37;
	localparam int RSVD_A_LO = 24;
	localparam int DESC_LOW_HI = 63;
	localparam int DESC_LOW_LO = 38;
	localparam int SOURCE_ID_HI = 79;
	localparam int SOURCE_ID_LO = 64;
	localparam int QUALIFIER_HI = 81;
	localparam int QUALIFIER_LO = 80;
	localparam int CHECK_TYPE_HI = 83;
	localparam int CHECK_TYPE_LO = 82;
	localparam int RSVD_B_HI = 95;
	localparam int RSVD_B_LO = 84;
	localparam int DESC_HIGH_HI = 127;
	localparam int DESC_HIGH_LO = 96;
	localparam int DESC_ALIGN_BITS = 6;

	// ********************************************************************
	// Source check encodings and compare masks
	// ********************************************************************
	localparam logic [1:0] CHECK_NONE = 2'h0;
	localparam logic [1:0] CHECK_REQUESTER = 2'h1;
	localparam logic [1:0] CHECK_BUS_RANGE = 2'h2;
	localparam logic [15:0] QUAL_MASK_0 = 16'hFFFF;
	localparam logic [15:0] QUAL_MASK_1 = 16'hFFFB;
	localparam logic [15:0] QUAL_MASK_2 = 16'hFFF9;
	localparam logic [15:0] QUAL_MASK_3 = 16'hFFF8;

	typedef enum logic [1:0] {
		OUT_BLOCKED = 2'b00,
		OUT_REMAP = 2'b01,
		OUT_POST = 2'b10
	} outcome_e;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] INT_CLEAR_OFFSET = 8'h08;
	localparam logic [7:0] INT_ENABLE_OFFSET = 8'h0C;
	localparam logic [7:0] LAST_OFFSET = 8'h10;
	localparam logic [7:0] BLOCK_COUNT_OFFSET = 8'h14;
	localparam int CTRL_CAP_BIT = 0;
	localparam int CTRL_WIDTH_LO = 8;
	localparam int CTRL_WIDTH_HI = 14;
	localparam logic [6:0] WIDTH_RESET = 7'h30;
	localparam logic CAP_RESET = 1'h1;
	localparam int EVENT_COUNT = 4;
	localparam int EV_POSTED = 0;
	localparam int EV_REMAPPED = 1;
	localparam int EV_BLOCKED = 2;
	localparam int EV_FAULT = 3;
	localparam logic [3:0] EVENT_RESET = 4'h0;

endpackage

// File: testbench/io_requester.sv
// Behavioural model of the I/O devices that reference remap table entries.
// Assumes callers run in step with the rising edge of clock.
module io_requester (
	input wire logic clock, // System clock.
	output logic reqValid, // Request strobe.
	output logic [127:0] reqEntry, // Entry that the request references.
	output logic [15:0] reqRequesterId // Requester id.
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reqValid = 1'b0;
		reqEntry = '1;
		reqRequesterId = 16'hFFFF;
	end

	// ********************************************************************
	// Request driver
	// ********************************************************************
	// Released lines show the inverse of the last value, so stale data never looks valid.
	// With keep set the strobe stays high and the next call follows with no gap.
	task automatic send(input logic [127:0] e, input logic [15:0] id, input bit keep);
		@(posedge clock);
		reqValid <= 1'b1;
		reqEntry <= e;
		reqRequesterId <= id;
		if (!keep) begin
			@(posedge clock);
			reqValid <= 1'b0;
			reqEntry <= ~e;
			reqRequesterId <= ~id;
		end
	endtask
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the posted-format entry decoder.
// Assumes the decoder answers one edge after a taken request or read strobe.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock, sys_rst, clockEnable, reqValid, regWrite, regRead, irq;
	logic resValid, resBlocked, resPosted, resRemapped, resUrgent, resFaultReport;
	logic [127:0] reqEntry, e;
	logic [15:0] reqRequesterId, id;
	logic [7:0] resVector, regAddr;
	logic [63:0] resDescAddr;
	logic [31:0] regWriteData, regReadData, seed, r, blkCnt, rexp;
	logic [76:0] exp, got;
	logic [76:0] q[$];
	logic [31:0] rq[$];
	logic cap, rdPend;
	logic [6:0] hostWidth;
	logic [15:0] ids[8] = '{16'h1234, 16'h1230, 16'h1236, 16'h1235, 16'h1200, 16'h3400, 16'h1100, 16'h3500};
	logic [15:0] lows[12] = '{16'h0000, 16'h0002, 16'h0001, 16'h8001, 16'hC001, 16'h4001, 16'h1001, 16'h2001,
		16'h0F01, 16'h0005, 16'h0081, 16'h8003};
	int failures = 0;
	int n_checks = 0;

	posted_entry_decode i_posted_entry_decode (.clock(clock), .sys_rst(sys_rst), .clockEnable(clockEnable),
		.reqValid(reqValid), .reqEntry(reqEntry), .reqRequesterId(reqRequesterId), .resValid(resValid),
		.resBlocked(resBlocked), .resPosted(resPosted), .resRemapped(resRemapped), .resUrgent(resUrgent),
		.resFaultReport(resFaultReport), .resVector(resVector), .resDescAddr(resDescAddr), .regAddr(regAddr),
		.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .irq(irq));
	io_requester i_io_requester (.clock(clock), .reqValid(reqValid), .reqEntry(reqEntry),
		.reqRequesterId(reqRequesterId));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ********************************************************************
	// Reference model and helpers
	// ********************************************************************
	function automatic logic [76:0] model(logic [127:0] x, logic [15:0] rid);
		logic [63:0] a;
		logic [15:0] m, s;
		logic ok, blk;
		a = {x[127:96], x[63:38], 6'h00};
		s = x[79:64];
		case (x[81:80])
			2'h0: m = 16'hFFFF;
			2'h1: m = 16'hFFFB;
			2'h2: m = 16'hFFF9;
			default: m = 16'hFFF8;
		endcase
		case (x[83:82])
			2'h0: ok = 1'b1;
			2'h1: ok = (s & m) == (rid & m);
			2'h2: ok = rid[15:8] >= s[15:8] && rid[15:8] <= s[7:0];
			default: ok = 1'b0;
		endcase
		blk = !x[0] || !ok || |x[95:84] || |x[37:24] || |x[13:12] || |x[7:2] || (a >> hostWidth) != 0
			|| (!cap && (x[15] || x[14]));
		return {blk, !blk & x[15], !blk & !x[15], !blk & x[15] & x[14], blk & !x[1],
			x[0] ? x[23:16] : 8'h00, x[0] ? a : 64'h0};
	endfunction

	// Every descriptor shares address bits 31:6 (26'h2ABCDEF); only bits 63:32 vary.
	function automatic logic [127:0] mk(logic [1:0] t, logic [1:0] qual, logic [15:0] srcId, logic [15:0] lo,
		logic [31:0] hi);
		return {hi, 12'h000, t, qual, srcId, 26'h2ABCDEF, 14'h0000, 8'hA5, lo};
	endfunction

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic req(input logic [127:0] x, input logic [15:0] rid, input bit keep);
		exp = model(x, rid);
		q.push_back(exp);
		if (exp[76]) blkCnt = blkCnt + 1;
		i_io_requester.send(x, rid, keep);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		rq.push_back(d);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
	endtask

	task automatic chkIrq(input logic v);
		repeat (2) @(posedge clock);
		@(negedge clock);
		n_checks++;
		if (irq !== v) begin
			failures++;
			$display("Error %0t: irq %b expected %b", $time, irq, v);
		end
	endtask

	task conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ********************************************************************
	// Result monitor
	// ********************************************************************
	always @(posedge clock) rdPend <= regRead & clockEnable;

	always @(negedge clock) begin
		if (rdPend === 1'b1) begin
			rexp = rq.pop_front();
			n_checks++;
			if (regReadData !== rexp) begin
				failures++;
				$display("Error %0t: read %h expected %h", $time, regReadData, rexp);
			end
		end
		if (resValid === 1'b1) begin
			got = {resBlocked, resPosted, resRemapped, resUrgent, resFaultReport, resVector, resDescAddr};
			n_checks++;
			if (q.size() == 0) begin
				failures++;
				$display("Error %0t: unexpected result", $time);
			end else begin
				exp = q.pop_front();
				if (got[76:72] !== exp[76:72]) begin
					failures++;
					$display("Error %0t: decision %b expected %b", $time, got[76:72], exp[76:72]);
				end
				if (got[71:0] !== exp[71:0]) begin
					failures++;
					$display("Error %0t: fields %h expected %h", $time, got[71:0], exp[71:0]);
				end
			end
		end
	end

	initial begin
		repeat (60000) @(posedge clock);
		failures++;
		$display("Error %0t: watchdog expired", $time);
		conclude();
	end

	// ********************************************************************
	// Test sequence
	// ********************************************************************
	initial begin
		sys_rst = 1'b1;
		clockEnable = 1'b1;
		regAddr = 8'h00;
		regWriteData = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		seed = 32'h867DF058;
		blkCnt = 32'h0;
		cap = 1'b1;
		hostWidth = 7'h30;
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		rd(8'h00, 32'h0000_3001);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h14, 32'h0);
		rd(8'h18, 32'h0);
		wr(8'h04, 32'hFFFF_FFFF);
		rd(8'h04, 32'h0);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0000_000F);
		wr(8'h0C, 32'h0);
		$display("test registers done");
		for (int t = 0; t < 4; t++)
			for (int s = 0; s < 4; s++)
				for (int k = 0; k < 8; k++)
					req(mk(t[1:0], s[1:0], 16'h1234, 16'h8001, 32'h1234), ids[k], k < 7);
		$display("test source check done");
		for (int h = 0; h < 2; h++)
			for (int k = 0; k < 12; k++)
				req(mk(2'h0, 2'h0, 16'h5678, lows[k], h ? 32'h0001_0000 : 32'h1234), 16'h0, k[0]);
		req(mk(2'h0, 2'h0, 16'h0, 16'hC001, 32'h1234), 16'h0, 1'b0);
		rd(8'h10, 32'h0000_06A5);
		rd(8'h04, 32'h0000_000F);
		$display("test entry fields done");
		wr(8'h00, 32'h0000_2800);
		cap = 1'b0;
		hostWidth = 7'h28;
		rd(8'h00, 32'h0000_2800);
		for (int h = 0; h < 2; h++)
			for (int k = 0; k < 12; k++)
				req(mk(2'h0, 2'h0, 16'h0, lows[k], h ? 32'h0000_0100 : 32'h34), 16'h0, 1'b0);
		wr(8'h00, 32'h0000_3001);
		cap = 1'b1;
		hostWidth = 7'h30;
		$display("test capability done");
		for (int k = 0; k < 300; k++) begin
			e = {xs(), xs(), xs(), xs()};
			r = xs();
			if (r[4:3] != 2'h0) e = e & 128'h0000FFFF_000FFFFF_FFFFFFC0_00FFCF03; // Reserved bits zeroed
			if (r[0]) e[0] = 1'b1;
			id = r[1] ? e[79:64] : r[31:16];
			req(e, id, k < 299);
		end
		rd(8'h14, blkCnt);
		$display("test random burst done");
		wr(8'h08, 32'h0000_000F);
		wr(8'h0C, 32'h0000_0004);
		chkIrq(1'b0);
		req(mk(2'h0, 2'h0, 16'h0, 16'h0000, 32'h1234), 16'h0, 1'b0);
		chkIrq(1'b1);
		rd(8'h04, 32'h0000_000C);
		wr(8'h0C, 32'h0);
		chkIrq(1'b0);
		wr(8'h0C, 32'h0000_0004);
		chkIrq(1'b1);
		wr(8'h08, 32'h0000_0004);
		chkIrq(1'b0);
		rd(8'h04, 32'h0000_0008);
		fork
			req(mk(2'h0, 2'h0, 16'h0, 16'h0000, 32'h1234), 16'h0, 1'b0);
			wr(8'h08, 32'h0000_0004);
		join
		rd(8'h04, 32'h0000_000C);
		$display("test interrupt done");
		@(posedge clock);
		clockEnable <= 1'b0;
		i_io_requester.send(mk(2'h0, 2'h0, 16'h0, 16'h0000, 32'h1234), 16'h0, 1'b0);
		wr(8'h0C, 32'h0000_000F);
		@(posedge clock);
		clockEnable <= 1'b1;
		rd(8'h0C, 32'h0000_0004);
		rd(8'h14, blkCnt);
		$display("test clock enable done");
		repeat (4) @(posedge clock);
		n_checks++;
		if (q.size() != 0 || rq.size() != 0) begin
			failures++;
			$display("Error %0t: %0d results and %0d reads never seen", $time, q.size(), rq.size());
		end
		conclude();
	end
endmodule
